// file: bench/rx_timing_afc_clock_output_pin_regs_bench.sv
// Self-checking bench of the receive timing register bank.
`default_nettype none
module rx_timing_afc_clock_output_pin_regs_bench;
  import rx_timing_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, irq_o;
  logic [0:0] sel_i = 1;
  logic [7:0] adr_i = 0, dat_i = 0, dat_o, q;
  logic entry = 0, rx_mode = 0, tick = 0, pbit = 0, pvalid = 0, done = 0, rc_clk = 0;
  logic rssi = 0, sync = 0, agc = 0, agc_en = 0, prev;
  logic [2:0] cerr = 0;
  logic [15:0] ferr = 0, corr, e;
  logic pev, tev, rst_o, trig, clk_o, act;
  int failures = 0, cmp_count = 0, seed = 19960, pc = 0, tc = 0, rc = 0, kc = 0, n;
  always #5 clk_i = ~clk_i;
  always #37 rc_clk = ~rc_clk;
  always @(posedge clk_i) begin
    pc += (pev === 1'b1);
    tc += (tev === 1'b1);
    rc += (rst_o === 1'b1);
    kc += (trig === 1'b1);
  end
  rx_timing_afc_clock_output_pin_regs dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .rx_mode_entry_i(entry), .rx_mode_i(rx_mode), .bit_tick_i(tick),
    .preamble_bit_i(pbit), .preamble_bit_valid_i(pvalid), .chip_errors_i(cerr),
    .rssi_event_i(rssi), .sync_match_event_i(sync), .agc_phase_i(agc),
    .agc_preamble_enable_i(agc_en), .packet_done_i(done), .freq_error_value_i(ferr),
    .rc_osc_clk_i(rc_clk), .freq_correction_value_o(corr), .preamble_detect_active_o(act),
    .preamble_event_o(pev), .timeout_event_o(tev), .rx_restart_o(rst_o),
    .rc_osc_calibrate_trigger_o(trig), .clock_output_pin_o(clk_o), .irq_o);
  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    cmp_count++;
    if (s !== x) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 0; stb_i <= 0; we_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    wb(0, a, 8'h00);
    chk({8'h00, q}, {8'h00, x});
  endtask
  task automatic ticks(input int k);
    repeat (k) begin
      tick <= 1; pvalid <= 1; @(posedge clk_i);
      tick <= 0; pvalid <= 0; @(posedge clk_i);
    end
    repeat (3) @(posedge clk_i);
  endtask
  task automatic rx_on();
    rx_mode <= 1; entry <= 1; @(posedge clk_i);
    entry <= 0; @(posedge clk_i);
  endtask
  function automatic int need(input int len);
    return (len + 1) * 8;
  endfunction
  function automatic int pre_hit(input int errs, input int tol);
    return (errs * need(0) <= tol) ? 1 : 0;
  endfunction
  function automatic int div_edges(input int s);
    if (s == 7) return 0;
    return (s == 0) ? 64 : 64 >> (s - 1);
  endfunction
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #300000;
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rd(ADDR_FREQ_CORR_HIGH, 8'h00); rd(ADDR_FREQ_CORR_LOW, 8'h00);
    rd(ADDR_PREAMBLE_CFG, RST_PREAMBLE_CFG); rd(ADDR_OSC_CTRL, 8'h07);
    for (int a = 8'h20; a < 8'h24; a++) rd(a[7:0], 8'h00);
    rd(8'h10, 8'h00);
    $display("resets done");
    repeat (8) begin
      e = 16'($random(seed));
      wb(1, ADDR_FREQ_CORR_HIGH, e[15:8]); wb(1, ADDR_FREQ_CORR_LOW, e[7:0]);
      chk(corr, e);
      ferr <= 16'($random(seed)); @(posedge clk_i); e = ferr;
      rd(ADDR_FREQ_ERR_HIGH, e[15:8]); ferr <= ~e;
      rd(ADDR_FREQ_ERR_LOW, e[7:0]);
    end
    wb(1, ADDR_OSC_CTRL, 8'h0D);
    rd(ADDR_OSC_CTRL, 8'h05); chk(kc, 1);
    $display("correction and error done");
    wb(1, ADDR_PREAMBLE_CFG, 8'h00); wb(1, ADDR_PREAMBLE_WAIT, 8'h01);
    wb(1, ADDR_IRQ_ENABLE, 8'h02); rx_on(); ticks(15);
    chk(tc, 0); ticks(1); chk(tc, 1); chk(irq_o, 1);
    rd(ADDR_IRQ_STATUS, 8'h02); wb(1, ADDR_IRQ_ENABLE, 8'h00); chk(irq_o, 0);
    wb(1, ADDR_IRQ_CLEAR, 8'h02); rd(ADDR_IRQ_STATUS, 8'h00);
    rx_mode <= 0; wb(1, ADDR_PREAMBLE_WAIT, 8'h00);
    $display("timeout done");
    pbit <= 1;
    for (int l = 0; l < 3; l++) begin
      wb(1, ADDR_PREAMBLE_CFG, {1'b1, l[1:0], 5'h0A}); pc = 0; rx_on();
      ticks(need(l) - 1); chk(pc, 0); ticks(1); chk(pc, 1);
      rx_mode <= 0; @(posedge clk_i);
    end
    for (int i = 0; i < 8; i++) begin
      n = $random(seed);
      if (i < 2) n = (8 - i) * 2048 + 1;
      cerr <= 3'(n[7:0] % 5); wb(1, ADDR_PREAMBLE_CFG, {3'b100, n[15:11]}); pc = 0; rx_on();
      ticks(need(0)); chk(pc, pre_hit(n[7:0] % 5, n[15:11]));
      rx_mode <= 0; @(posedge clk_i);
    end
    cerr <= 0; wb(1, ADDR_PREAMBLE_CFG, 8'hEA); pc = 0; rx_on();
    ticks(need(3)); chk(pc, 0);
    rx_mode <= 0;
    $display("preamble done");
    pbit <= 0; wb(1, ADDR_RX_CONTROL, 8'h01); wb(1, ADDR_RESTART_DELAY, 8'h01); rx_on();
    done <= 1; @(posedge clk_i); done <= 0;
    ticks(3); chk(rc, 0); ticks(1); chk(rc, 1);
    $display("restart done");
    rx_mode <= 0; wb(1, ADDR_RX_CONTROL, 8'h00); wb(1, ADDR_RSSI_WAIT, 8'h01); tc = 0; rx_on();
    ticks(8); rssi <= 1; @(posedge clk_i); rssi <= 0; ticks(8); chk(tc, 0);
    rx_on(); ticks(16); chk(tc, 1);
    wb(1, ADDR_RSSI_WAIT, 8'h00); wb(1, ADDR_SYNC_WAIT, 8'h02); tc = 0; rx_on();
    ticks(20); sync <= 1; @(posedge clk_i); sync <= 0; ticks(20); chk(tc, 0);
    rx_on(); ticks(32); chk(tc, 1);
    rx_mode <= 0; wb(1, ADDR_SYNC_WAIT, 8'h00);
    $display("rssi and sync timeouts done");
    wb(1, ADDR_PREAMBLE_CFG, 8'h00); agc <= 1; agc_en <= 1; rx_on(); @(posedge clk_i);
    chk(act, 1); agc_en <= 0; wb(1, ADDR_PREAMBLE_CFG, RST_PREAMBLE_CFG); chk(act, 0);
    agc <= 0; repeat (2) @(posedge clk_i); chk(act, 1);
    rx_mode <= 0; repeat (2) @(posedge clk_i); chk(act, 0);
    $display("override done");
    for (int s = 0; s < 8; s++) begin
      if (s != 6) begin
        wb(1, ADDR_OSC_CTRL, s[7:0]); repeat (2) @(posedge clk_i);
        n = 0; prev = clk_o;
        repeat (64) begin
          @(posedge clk_i);
          if (clk_o !== prev) n++;
          prev = clk_o;
        end
        chk(n, div_edges(s));
      end
    end
    $display("clock output done");
    rd(ADDR_IRQ_STATUS, 8'h0F); wb(1, ADDR_IRQ_CLEAR, 8'h0F); rd(ADDR_IRQ_STATUS, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire

// file: bench/rx_timing_chk.sv
// Checker of bus handshake and register behaviour of the receive timing bank.
`default_nettype none
module rx_timing_chk
  import rx_timing_pkg::*;
(
  input wire logic clk_i, rst_i, cyc_i, stb_i, we_i,
  input wire logic [7:0] adr_i,
  input wire logic [0:0] sel_i,
  input wire logic [7:0] dat_i, dat_o,
  input wire logic ack_o, rx_mode_i,
  input wire logic [15:0] freq_correction_value_o,
  input wire logic preamble_detect_active_o, timeout_event_o,
  input wire logic rx_restart_o, rc_osc_calibrate_trigger_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] wdat;
  always_ff @(posedge clk_i) begin
    if (cyc_i && stb_i && we_i) begin
      wdat <= dat_i;
    end
  end
  sequence take_s;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence wr_s(logic [7:0] a);
    take_s ##0 (we_i && sel_i[0] && adr_i == a);
  endsequence
  ack_answer_a: assert property (take_s |=> ack_o) else $error("ack missing");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
  corr_high_a: assert property (
    wr_s(ADDR_FREQ_CORR_HIGH) |-> ##[1:2] freq_correction_value_o[15:8] == wdat)
    else $error("high correction not applied");
  corr_low_a: assert property (
    wr_s(ADDR_FREQ_CORR_LOW) |-> ##[1:2] freq_correction_value_o[7:0] == wdat)
    else $error("low correction not applied");
  cal_reads_zero_a: assert property (
    ack_o && !we_i && adr_i == ADDR_OSC_CTRL |-> dat_o[7:3] == 5'h00)
    else $error("oscillator upper bits not zero");
  cal_pulse_a: assert property (
    rc_osc_calibrate_trigger_o |=> !rc_osc_calibrate_trigger_o) else $error("trigger long");
  timeout_rx_a: assert property (
    timeout_event_o |-> $past(rx_mode_i) ##1 !timeout_event_o) else $error("bad timeout");
  detect_idle_a: assert property (
    !$past(rx_mode_i) |-> !preamble_detect_active_o) else $error("detector on outside rx");
  restart_pulse_a: assert property (
    rx_restart_o |=> !rx_restart_o) else $error("restart long");
endmodule
bind rx_timing_afc_clock_output_pin_regs rx_timing_chk chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
  .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .rx_mode_i, .freq_correction_value_o,
  .preamble_detect_active_o, .timeout_event_o, .rx_restart_o, .rc_osc_calibrate_trigger_o);
`default_nettype wire

// file: src/rx_timing_afc_clock_output_pin_regs.sv
// Receive timing, frequency correction, preamble detect and clock output register bank.
//
// Implementation choice: the Wishbone slave port.
`default_nettype none
module rx_timing_afc_clock_output_pin_regs
  import rx_timing_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [0:0] sel_i,
  input wire logic [7:0] dat_i,
  output logic [7:0] dat_o,
  output logic ack_o,
  // Receiver events, same clock; rc_osc_clk_i is asynchronous and synchronised inside.
  input wire logic rx_mode_entry_i,
  input wire logic rx_mode_i,
  input wire logic bit_tick_i,
  input wire logic preamble_bit_i,
  input wire logic preamble_bit_valid_i,
  input wire logic [2:0] chip_errors_i,
  input wire logic rssi_event_i,
  input wire logic sync_match_event_i,
  input wire logic agc_phase_i,
  input wire logic agc_preamble_enable_i,
  input wire logic packet_done_i,
  input wire logic [15:0] freq_error_value_i,
  input wire logic rc_osc_clk_i,
  // Outputs.
  output logic [15:0] freq_correction_value_o,
  output logic preamble_detect_active_o,
  output logic preamble_event_o,
  output logic timeout_event_o,
  output logic rx_restart_o,
  output logic rc_osc_calibrate_trigger_o,
  output logic clock_output_pin_o,
  output logic irq_o
);
  import rx_timing_pkg::*;

  // ----------------------------------------
  // Register storage and bus decode
  // ----------------------------------------
  logic [7:0] corr_high;
  logic [7:0] corr_low;
  logic [7:0] err_low_hold;
  logic [7:0] preamble_cfg;
  logic [7:0] rssi_wait_limit;
  logic [7:0] preamble_wait_limit;
  logic [7:0] sync_wait_limit;
  logic [7:0] restart_wait_count;
  logic [2:0] clock_output_select;
  logic [3:0] irq_status;
  logic [3:0] irq_enable;
  logic auto_restart_en;
  logic [3:0] irq_set;
  logic rc_osc_s1;
  logic rc_osc_s2;
  logic [7:0] next_dat;
  logic bus_req;
  logic wr_en;
  logic rd_en;

  assign bus_req = cyc_i && stb_i && !ack_o;
  assign wr_en = bus_req && we_i && sel_i[0];
  assign rd_en = bus_req && !we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      corr_high <= RST_FREQ_CORR;
      corr_low <= RST_FREQ_CORR;
    end else if (wr_en && adr_i == ADDR_FREQ_CORR_HIGH) begin
      corr_high <= dat_i;
    end else if (wr_en && adr_i == ADDR_FREQ_CORR_LOW) begin
      corr_low <= dat_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freq_correction_value_o <= {RST_FREQ_CORR, RST_FREQ_CORR};
    end else begin
      freq_correction_value_o <= {corr_high, corr_low};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      preamble_cfg <= RST_PREAMBLE_CFG;
      rssi_wait_limit <= RST_TIMEOUT;
      preamble_wait_limit <= RST_TIMEOUT;
      sync_wait_limit <= RST_TIMEOUT;
      restart_wait_count <= RST_TIMEOUT;
      clock_output_select <= RST_CLOCK_SEL;
      irq_enable <= 4'h0;
      auto_restart_en <= 1'b0;
    end else if (wr_en) begin
      case (adr_i)
        ADDR_PREAMBLE_CFG: preamble_cfg <= dat_i;
        ADDR_RSSI_WAIT: rssi_wait_limit <= dat_i;
        ADDR_PREAMBLE_WAIT: preamble_wait_limit <= dat_i;
        ADDR_SYNC_WAIT: sync_wait_limit <= dat_i;
        ADDR_RESTART_DELAY: restart_wait_count <= dat_i;
        ADDR_OSC_CTRL: clock_output_select <= dat_i[2:0];
        ADDR_IRQ_ENABLE: irq_enable <= dat_i[3:0];
        ADDR_RX_CONTROL: auto_restart_en <= dat_i[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_low_hold <= 8'h00;
    end else if (rd_en && adr_i == ADDR_FREQ_ERR_HIGH) begin
      err_low_hold <= freq_error_value_i[7:0];
    end
  end

  always_comb begin
    next_dat = 8'h00;
    case (adr_i)
      ADDR_FREQ_CORR_HIGH: next_dat = corr_high;
      ADDR_FREQ_CORR_LOW: next_dat = corr_low;
      ADDR_FREQ_ERR_HIGH: next_dat = freq_error_value_i[15:8];
      ADDR_FREQ_ERR_LOW: next_dat = err_low_hold;
      ADDR_PREAMBLE_CFG: next_dat = preamble_cfg;
      ADDR_RSSI_WAIT: next_dat = rssi_wait_limit;
      ADDR_PREAMBLE_WAIT: next_dat = preamble_wait_limit;
      ADDR_SYNC_WAIT: next_dat = sync_wait_limit;
      ADDR_RESTART_DELAY: next_dat = restart_wait_count;
      ADDR_OSC_CTRL: next_dat = {5'h00, clock_output_select};
      ADDR_IRQ_STATUS: next_dat = {4'h0, irq_status};
      ADDR_IRQ_ENABLE: next_dat = {4'h0, irq_enable};
      ADDR_RX_CONTROL: next_dat = {7'h00, auto_restart_en};
      default: next_dat = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 8'h00;
    end else if (rd_en) begin
      dat_o <= next_dat;
    end
  end

  // ----------------------------------------
  // Preamble detector
  // ----------------------------------------
  logic detect_on;
  logic [4:0] bit_count;
  logic [5:0] err_count;
  logic [4:0] bits_needed;
  logic [5:0] next_err;

  assign detect_on = agc_phase_i ? agc_preamble_enable_i : preamble_cfg[PRE_ENABLE_BIT];
  assign bits_needed = {preamble_cfg[PRE_LEN_MSB:PRE_LEN_LSB] + 2'd1, 3'b000};
  assign next_err = err_count + {3'b000, chip_errors_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      preamble_detect_active_o <= 1'b0;
    end else begin
      preamble_detect_active_o <= detect_on && rx_mode_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_count <= 5'h00;
      err_count <= 6'h00;
      preamble_event_o <= 1'b0;
    end else begin
      preamble_event_o <= 1'b0;
      if (!detect_on || !rx_mode_i || rx_mode_entry_i ||
          preamble_cfg[PRE_LEN_MSB:PRE_LEN_LSB] == 2'b11) begin
        bit_count <= 5'h00;
        err_count <= 6'h00;
      end else if (preamble_bit_valid_i) begin
        if (!preamble_bit_i ||
            next_err > {1'b0, preamble_cfg[PRE_TOL_MSB:0]}) begin
          bit_count <= 5'h00;
          err_count <= 6'h00;
        end else if (bit_count + 5'd1 == bits_needed) begin
          preamble_event_o <= 1'b1;
          bit_count <= 5'h00;
          err_count <= 6'h00;
        end else begin
          bit_count <= bit_count + 5'd1;
          err_count <= next_err;
        end
      end
    end
  end

  // ----------------------------------------
  // Receive timeouts and restart delay
  // ----------------------------------------
  logic [11:0] rx_bits;
  logic rssi_seen;
  logic preamble_seen;
  logic sync_seen;
  rx_state_t rx_state;
  logic [9:0] delay_bits;
  logic timeout_hit;

  assign timeout_hit = bit_tick_i && (
    (rssi_wait_limit != 8'h00 && !rssi_seen &&
     rx_bits + 12'd1 == 12'(rssi_wait_limit * TIMEOUT_BIT_MULT)) ||
    (preamble_wait_limit != 8'h00 && !preamble_seen &&
     rx_bits + 12'd1 == 12'(preamble_wait_limit * TIMEOUT_BIT_MULT)) ||
    (sync_wait_limit != 8'h00 && !sync_seen &&
     rx_bits + 12'd1 == 12'(sync_wait_limit * TIMEOUT_BIT_MULT)));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_bits <= 12'h000;
      rssi_seen <= 1'b0;
      preamble_seen <= 1'b0;
      sync_seen <= 1'b0;
      timeout_event_o <= 1'b0;
    end else if (rx_mode_entry_i || !rx_mode_i) begin
      rx_bits <= 12'h000;
      rssi_seen <= 1'b0;
      preamble_seen <= 1'b0;
      sync_seen <= 1'b0;
      timeout_event_o <= 1'b0;
    end else begin
      timeout_event_o <= timeout_hit;
      if (bit_tick_i && rx_bits != 12'hFFF) begin
        rx_bits <= rx_bits + 12'd1;
      end
      rssi_seen <= rssi_seen || rssi_event_i;
      preamble_seen <= preamble_seen || preamble_event_o;
      sync_seen <= sync_seen || sync_match_event_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state <= RX_IDLE;
      delay_bits <= 10'h000;
      rx_restart_o <= 1'b0;
    end else begin
      rx_restart_o <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          if (auto_restart_en && rx_mode_i) begin
            rx_state <= RX_WAIT;
          end
        end
        RX_WAIT: begin
          if (!rx_mode_i) begin
            rx_state <= RX_IDLE;
          end else if (packet_done_i) begin
            delay_bits <= 10'h000;
            rx_state <= RX_DELAY;
          end
        end
        RX_DELAY: begin
          if (delay_bits == 10'(restart_wait_count * RESTART_BIT_MULT)) begin
            rx_restart_o <= 1'b1;
            rx_state <= RX_IDLE;
          end else if (bit_tick_i) begin
            delay_bits <= delay_bits + 10'd1;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // RC calibration and clock output
  // ----------------------------------------
  logic [6:0] cal_count;
  logic [4:0] div_count;
  logic next_clk_out;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rc_osc_calibrate_trigger_o <= 1'b0;
      cal_count <= 7'h00;
    end else begin
      rc_osc_calibrate_trigger_o <= wr_en && adr_i == ADDR_OSC_CTRL && dat_i[RC_CAL_BIT];
      if (rc_osc_calibrate_trigger_o) begin
        cal_count <= 7'(RC_CAL_CYCLES);
      end else if (cal_count != 7'h00) begin
        cal_count <= cal_count - 7'd1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rc_osc_s1 <= 1'b0;
      rc_osc_s2 <= 1'b0;
      div_count <= 5'h00;
    end else begin
      rc_osc_s1 <= rc_osc_clk_i;
      rc_osc_s2 <= rc_osc_s1;
      div_count <= div_count + 5'd1;
    end
  end

  always_comb begin
    next_clk_out = 1'b0;
    case (clock_output_select)
      3'h0: next_clk_out = ~clock_output_pin_o;
      3'h1: next_clk_out = div_count[0];
      3'h2: next_clk_out = div_count[1];
      3'h3: next_clk_out = div_count[2];
      3'h4: next_clk_out = div_count[3];
      3'h5: next_clk_out = div_count[4];
      CLK_SEL_RC: next_clk_out = rc_osc_s2;
      CLK_SEL_OFF: next_clk_out = 1'b0;
      default: next_clk_out = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_output_pin_o <= 1'b0;
    end else begin
      clock_output_pin_o <= next_clk_out;
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign irq_set = {rc_osc_calibrate_trigger_o && cal_count == 7'h00 ? 1'b0 :
                    cal_count == 7'd1, rx_restart_o, timeout_event_o, preamble_event_o};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= 4'h0;
    end else if (wr_en && adr_i == ADDR_IRQ_CLEAR) begin
      irq_status <= (irq_status & ~dat_i[3:0]) | irq_set;
    end else begin
      irq_status <= irq_status | irq_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_enable);
    end
  end
endmodule
`default_nettype wire

// file: src/rx_timing_pkg.sv
// Package with register map, field layout and timing constants of the receive timing bank.
`default_nettype none
package rx_timing_pkg;
  localparam logic [7:0] ADDR_FREQ_CORR_HIGH = 8'h1B;
  localparam logic [7:0] ADDR_FREQ_CORR_LOW = 8'h1C;
  localparam logic [7:0] ADDR_FREQ_ERR_HIGH = 8'h1D;
  localparam logic [7:0] ADDR_FREQ_ERR_LOW = 8'h1E;
  localparam logic [7:0] ADDR_PREAMBLE_CFG = 8'h1F;
  localparam logic [7:0] ADDR_RSSI_WAIT = 8'h20;
  localparam logic [7:0] ADDR_PREAMBLE_WAIT = 8'h21;
  localparam logic [7:0] ADDR_SYNC_WAIT = 8'h22;
  localparam logic [7:0] ADDR_RESTART_DELAY = 8'h23;
  localparam logic [7:0] ADDR_OSC_CTRL = 8'h24;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h30;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h31;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h32;
  localparam logic [7:0] ADDR_RX_CONTROL = 8'h33;
  localparam logic [7:0] RST_FREQ_CORR = 8'h00;
  localparam logic [7:0] RST_PREAMBLE_CFG = 8'hAA;
  localparam logic [7:0] RST_TIMEOUT = 8'h00;
  localparam logic [2:0] RST_CLOCK_SEL = 3'h7;
  localparam int PRE_ENABLE_BIT = 7;
  localparam int PRE_LEN_MSB = 6;
  localparam int PRE_LEN_LSB = 5;
  localparam int PRE_TOL_MSB = 4;
  localparam int RC_CAL_BIT = 3;
  localparam int IRQ_PREAMBLE = 0;
  localparam int IRQ_TIMEOUT = 1;
  localparam int IRQ_RESTART = 2;
  localparam int IRQ_RC_CAL = 3;
  localparam int TIMEOUT_BIT_MULT = 16;
  localparam int RESTART_BIT_MULT = 4;
  localparam int CHIPS_PER_BIT = 4;
  localparam logic [2:0] CLK_SEL_RC = 3'h6;
  localparam logic [2:0] CLK_SEL_OFF = 3'h7;
  localparam int CLK_FREQ_HZ = 100000000;
  localparam int RC_CAL_TIME_US = 1;
  localparam int RC_CAL_CYCLES = (CLK_FREQ_HZ / 1000000) * RC_CAL_TIME_US;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_WAIT = 2'b01,
    RX_DELAY = 2'b11
  } rx_state_t;
endpackage
`default_nettype wire
